// ### hw/bcmpc_consts.svh
// Constants for the battery cell monitor pin control block
`ifndef BCMPC_CONSTS_SVH
`define BCMPC_CONSTS_SVH
`define BCMPC_CLK_KHZ          200000
`define BCMPC_WDT_TIMEOUT_MS   2500
`define BCMPC_WDT_CYCLES       (`BCMPC_WDT_TIMEOUT_MS * `BCMPC_CLK_KHZ)
`define BCMPC_CELL_COUNT       12
`define BCMPC_ADC_WIDTH        12
`define BCMPC_NUM_CH           14
`define BCMPC_CH_TEMP1         4'hC
`define BCMPC_CH_TEMP2         4'hD
`define BCMPC_GPIO_CFG_RST     2'h3
`define BCMPC_SYNC_W           12
`define BCMPC_SI_SCK           0
`define BCMPC_SI_CS_N          1
`define BCMPC_SI_MM_N          2
`define BCMPC_SI_TOS           3
`define BCMPC_SI_ADDR          4
`define BCMPC_SI_GP1           8
`define BCMPC_SI_GP2           9
`define BCMPC_SI_WDT           10
`define BCMPC_SI_SPARE         11
`endif

// ### hw/bcmpc_pkg.sv
// Types shared by the battery cell monitor pin control block
`include "bcmpc_consts.svh"
package bcmpc_pkg;
    typedef logic [`BCMPC_ADC_WIDTH-1:0] bcmpc_word_t;
    typedef enum logic [1:0] {
        CV_IDLE,
        CV_START,
        CV_WAIT
    } bcmpc_conv_state_t;
endpackage : bcmpc_pkg

// ### hw/bcmpc_pin_ctrl.sv
// Pin control, watchdog and conversion sequencing of the battery cell monitor
`include "bcmpc_consts.svh"
// Summary of operation
// - Assert watchdog when serial clock stays idle for 2.5 seconds.
// - Asserted watchdog pulls its pin low outside monitor mode and restores configuration defaults.
// - Watchdog pin only sinks low, never drives high.
// - With monitor-mode input high, general pins act as ordinary I/O.
// - General pin configuration bit 0 turns on the pull-down.
// - General pin configuration bit 1 leaves the pin floating.
// - Reading general pin bits returns pin levels; written 0 reads 0.
// - Monitor mode while the active-low monitor-mode input is low.
// - In monitor mode general and watchdog pins are cell-count inputs.
// - Bus address comes from four strapped address inputs.
// - Top-of-stack strap changes serial output behaviour in polling mode.
// - Serial output is open-drain only; outside party pulls it up.
// - Discharge switches change only by host configuration writes or a watchdog clear.
// - Open-wire conversion enables test currents for every cell conversion.
// - Normal cell conversion keeps test currents off.
// - Up to 12 cells go one by one to a single 12-bit converter.
// - Two temperature inputs are converted and kept in result registers.
// - Act on configuration writes and conversion commands only with the own address; serial output drive ignores the address.
module bcmpc_pin_ctrl
    import bcmpc_pkg::*;
#(
    parameter int unsigned WDT_CYCLES = `BCMPC_WDT_CYCLES,
    parameter int unsigned CELLS      = `BCMPC_CELL_COUNT
) (
    input  wire logic              REF_CLK,
    input  wire logic              RESET_N,
    input  wire logic              SERIAL_CLOCK_IN,
    input  wire logic              CHIP_SELECT_IN_N,
    input  wire logic              MONITOR_MODE_SEL_N,
    input  wire logic              TOP_OF_STACK_SEL,
    input  wire logic              ADDR_STRAP_BIT0,
    input  wire logic              ADDR_STRAP_BIT1,
    input  wire logic              ADDR_STRAP_BIT2,
    input  wire logic              ADDR_STRAP_BIT3,
    input  wire logic              SERIAL_DATA_OUT_OD_I,
    output logic                   SERIAL_DATA_OUT_OD_O,
    output logic                   SERIAL_DATA_OUT_OD_OE,
    input  wire logic              WATCHDOG_OUT_N_I,
    output logic                   WATCHDOG_OUT_N_O,
    output logic                   WATCHDOG_OUT_N_OE,
    input  wire logic              GENERAL_PIN_ONE_I,
    output logic                   GENERAL_PIN_ONE_O,
    output logic                   GENERAL_PIN_ONE_OE,
    input  wire logic              GENERAL_PIN_TWO_I,
    output logic                   GENERAL_PIN_TWO_O,
    output logic                   GENERAL_PIN_TWO_OE,
    input  wire logic [3:0]        CMD_ADDR,
    input  wire logic              CFG_WR,
    input  wire logic [1:0]        CFG_GPIO_WDATA,
    input  wire logic [CELLS-1:0]  CFG_DISCHARGE_WDATA,
    input  wire logic              NORMAL_CELL_CONVERT_CMD,
    input  wire logic              OPEN_WIRE_CONVERT_CMD,
    input  wire logic              TEMP_CONVERT_CMD,
    input  wire logic              POLL_MODE,
    input  wire logic              SDO_BIT,
    input  wire logic              ADC_DONE,
    input  wire bcmpc_word_t       ADC_DATA,
    input  wire logic [3:0]        RD_IDX,
    output logic [CELLS-1:0]       DISCHARGE_EN,
    output logic [1:0]             GPIO_READBACK,
    output logic                   MONITOR_MODE,
    output logic [2:0]             CELL_COUNT_SEL,
    output logic [3:0]             DEVICE_ADDR,
    output logic                   ADDR_MATCH,
    output logic                   WATCHDOG_ACTIVE,
    output logic                   CONV_BUSY,
    output logic                   ADC_START,
    output logic [3:0]             MUX_SEL,
    output logic                   TEST_CURRENT_EN,
    output bcmpc_word_t            RD_DATA
);

    localparam logic [31:0] WDT_LAST  = 32'(WDT_CYCLES - 1);
    localparam logic [3:0]  LAST_CELL = 4'(CELLS - 1);

    logic [`BCMPC_SYNC_W-1:0] async_in;
    logic [`BCMPC_SYNC_W-1:0] sync1_r;
    logic [`BCMPC_SYNC_W-1:0] sync2_r;
    logic                     sck_d_r;
    logic                     sck_edge;
    logic                     mm;
    logic                     cs_act;
    logic                     match;

    // The watchdog and general pins are read back too; the pad level is what counts
    assign async_in = {1'b0, WATCHDOG_OUT_N_I, GENERAL_PIN_TWO_I, GENERAL_PIN_ONE_I,
                       ADDR_STRAP_BIT3, ADDR_STRAP_BIT2, ADDR_STRAP_BIT1, ADDR_STRAP_BIT0,
                       TOP_OF_STACK_SEL, MONITOR_MODE_SEL_N, CHIP_SELECT_IN_N,
                       SERIAL_CLOCK_IN};

    for (genvar gi = 0; gi < `BCMPC_SYNC_W; gi++) begin : g_sync
        always_ff @(posedge REF_CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                sync1_r[gi] <= 1'b1;
                sync2_r[gi] <= 1'b1;
            end else begin
                sync1_r[gi] <= async_in[gi];
                sync2_r[gi] <= sync1_r[gi];
            end
        end
    end

    assign sck_edge = sync2_r[`BCMPC_SI_SCK] ^ sck_d_r;
    assign mm       = ~sync2_r[`BCMPC_SI_MM_N];
    assign cs_act   = ~sync2_r[`BCMPC_SI_CS_N];
    assign match    = (CMD_ADDR == DEVICE_ADDR);

    // Watchdog and configuration state
    logic [31:0]      wdt_cnt_r;
    logic [31:0]      wdt_cnt_nxt;
    logic             wdt_act_nxt;
    logic [1:0]       gpio_cfg_r;
    logic [1:0]       gpio_cfg_nxt;
    logic [CELLS-1:0] dis_nxt;

    always_comb begin
        wdt_cnt_nxt  = wdt_cnt_r;
        wdt_act_nxt  = WATCHDOG_ACTIVE;
        gpio_cfg_nxt = gpio_cfg_r;
        dis_nxt      = DISCHARGE_EN;
        if (sck_edge) begin
            wdt_cnt_nxt = 32'h0000_0000;
            wdt_act_nxt = 1'b0;
        end else if (wdt_cnt_r == WDT_LAST) begin
            wdt_act_nxt = 1'b1;
        end else begin
            wdt_cnt_nxt = wdt_cnt_r + 32'h0000_0001;
        end
        // Watchdog holds the defaults and beats any write while it stays asserted
        if (WATCHDOG_ACTIVE) begin
            gpio_cfg_nxt = `BCMPC_GPIO_CFG_RST;
            dis_nxt      = '0;
        end else if (CFG_WR && match) begin
            gpio_cfg_nxt = CFG_GPIO_WDATA;
            dis_nxt      = CFG_DISCHARGE_WDATA;
        end
    end

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sck_d_r         <= 1'b1;
            wdt_cnt_r       <= 32'h0000_0000;
            WATCHDOG_ACTIVE <= 1'b0;
            gpio_cfg_r      <= `BCMPC_GPIO_CFG_RST;
            DISCHARGE_EN    <= '0;
        end else begin
            sck_d_r         <= sync2_r[`BCMPC_SI_SCK];
            wdt_cnt_r       <= wdt_cnt_nxt;
            WATCHDOG_ACTIVE <= wdt_act_nxt;
            gpio_cfg_r      <= gpio_cfg_nxt;
            DISCHARGE_EN    <= dis_nxt;
        end
    end

    // Conversion sequencer
    bcmpc_conv_state_t st_r;
    bcmpc_conv_state_t st_nxt;
    logic [3:0]        chan_nxt;
    logic [3:0]        last_r;
    logic [3:0]        last_nxt;
    logic              ow_r;
    logic              ow_nxt;
    bcmpc_word_t       res_r   [`BCMPC_NUM_CH];
    bcmpc_word_t       res_nxt [`BCMPC_NUM_CH];

    always_comb begin
        st_nxt   = st_r;
        chan_nxt = MUX_SEL;
        last_nxt = last_r;
        ow_nxt   = ow_r;
        res_nxt  = res_r;
        case (st_r)
            CV_IDLE: begin
                // Open-wire wins over normal, normal over temperature
                if (match && (OPEN_WIRE_CONVERT_CMD || NORMAL_CELL_CONVERT_CMD)) begin
                    st_nxt   = CV_START;
                    chan_nxt = 4'h0;
                    last_nxt = LAST_CELL;
                    ow_nxt   = OPEN_WIRE_CONVERT_CMD;
                end else if (match && TEMP_CONVERT_CMD) begin
                    st_nxt   = CV_START;
                    chan_nxt = `BCMPC_CH_TEMP1;
                    last_nxt = `BCMPC_CH_TEMP2;
                    ow_nxt   = 1'b0;
                end
            end
            CV_START: begin
                st_nxt = CV_WAIT;
            end
            CV_WAIT: begin
                if (ADC_DONE) begin
                    res_nxt[MUX_SEL] = ADC_DATA;
                    if (MUX_SEL == last_r) begin
                        st_nxt = CV_IDLE;
                        ow_nxt = 1'b0;
                    end else begin
                        st_nxt   = CV_START;
                        chan_nxt = MUX_SEL + 4'h1;
                    end
                end
            end
            default: begin
                st_nxt = CV_IDLE;
                ow_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_r            <= CV_IDLE;
            MUX_SEL         <= 4'h0;
            last_r          <= 4'h0;
            ow_r            <= 1'b0;
            CONV_BUSY       <= 1'b0;
            ADC_START       <= 1'b0;
            TEST_CURRENT_EN <= 1'b0;
            for (int i = 0; i < `BCMPC_NUM_CH; i++) begin
                res_r[i] <= '0;
            end
        end else begin
            st_r            <= st_nxt;
            MUX_SEL         <= chan_nxt;
            last_r          <= last_nxt;
            ow_r            <= ow_nxt;
            CONV_BUSY       <= (st_nxt != CV_IDLE);
            ADC_START       <= (st_nxt == CV_START);
            TEST_CURRENT_EN <= ow_nxt && (st_nxt != CV_IDLE);
            res_r           <= res_nxt;
        end
    end

    // Pin drivers and status outputs
    logic        poll_tog_r;
    logic        poll_tog_nxt;
    logic        sdo_oe_nxt;
    bcmpc_word_t rd_nxt;

    always_comb begin
        poll_tog_nxt = poll_tog_r;
        if (!CONV_BUSY) begin
            poll_tog_nxt = 1'b0;
        end else if (sck_edge) begin
            poll_tog_nxt = ~poll_tog_r;
        end
        // Line is only ever pulled low; a high level needs the outside pull-up
        if (!cs_act) begin
            sdo_oe_nxt = 1'b0;
        end else if (POLL_MODE) begin
            sdo_oe_nxt = sync2_r[`BCMPC_SI_TOS] ? CONV_BUSY : poll_tog_nxt;
        end else begin
            sdo_oe_nxt = ~SDO_BIT;
        end
        rd_nxt = (RD_IDX < 4'(`BCMPC_NUM_CH)) ? res_r[RD_IDX] : '0;
    end

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            poll_tog_r            <= 1'b0;
            SERIAL_DATA_OUT_OD_OE <= 1'b0;
            WATCHDOG_OUT_N_OE     <= 1'b0;
            GENERAL_PIN_ONE_OE    <= 1'b0;
            GENERAL_PIN_TWO_OE    <= 1'b0;
            GPIO_READBACK         <= 2'h0;
            MONITOR_MODE          <= 1'b0;
            CELL_COUNT_SEL        <= 3'h0;
            DEVICE_ADDR           <= 4'h0;
            ADDR_MATCH            <= 1'b0;
            RD_DATA               <= '0;
        end else begin
            poll_tog_r            <= poll_tog_nxt;
            SERIAL_DATA_OUT_OD_OE <= sdo_oe_nxt;
            WATCHDOG_OUT_N_OE     <= wdt_act_nxt && !mm;
            GENERAL_PIN_ONE_OE    <= !mm && !gpio_cfg_nxt[0];
            GENERAL_PIN_TWO_OE    <= !mm && !gpio_cfg_nxt[1];
            // Masking with the setting hides the synchroniser lag on a driven-low pin
            GPIO_READBACK         <= sync2_r[`BCMPC_SI_GP2:`BCMPC_SI_GP1] & gpio_cfg_r;
            MONITOR_MODE          <= mm;
            CELL_COUNT_SEL        <= mm ? sync2_r[`BCMPC_SI_WDT:`BCMPC_SI_GP1] : 3'h0;
            // Straps are re-sampled continuously, so they settle after reset
            DEVICE_ADDR           <= sync2_r[`BCMPC_SI_ADDR+3:`BCMPC_SI_ADDR];
            ADDR_MATCH            <= match;
            RD_DATA               <= rd_nxt;
        end
    end

    // Open-drain pads: the output value is always low, only the enable moves
    assign SERIAL_DATA_OUT_OD_O = 1'b0;
    assign WATCHDOG_OUT_N_O     = 1'b0;
    assign GENERAL_PIN_ONE_O    = 1'b0;
    assign GENERAL_PIN_TWO_O    = 1'b0;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);

    chk_wdt_timeout: assert property ((wdt_cnt_r == WDT_LAST) && !sck_edge |=> WATCHDOG_ACTIVE)
        else $error("watchdog did not fire at timeout");
    chk_wdt_pin_low: assert property (WATCHDOG_ACTIVE && !mm && !sck_edge |=> WATCHDOG_OUT_N_OE)
        else $error("watchdog pin not pulled low");
    chk_wdt_never_high: assert property (!WATCHDOG_OUT_N_O && (WATCHDOG_OUT_N_OE -> WATCHDOG_ACTIVE))
        else $error("watchdog pin driven without cause");
    chk_cfg_default: assert property (WATCHDOG_ACTIVE |=> DISCHARGE_EN == '0 && gpio_cfg_r == 2'h3)
        else $error("configuration not reset by watchdog");
    chk_wdt_release: assert property (sck_edge |=> !WATCHDOG_ACTIVE && wdt_cnt_r == 32'h0)
        else $error("serial clock edge did not restart watchdog");
    chk_gpio_drive: assert property (!mm && !gpio_cfg_nxt[0] |=> GENERAL_PIN_ONE_OE)
        else $error("general pin one not pulled low");
    chk_gpio_float: assert property (gpio_cfg_nxt[1] |=> !GENERAL_PIN_TWO_OE)
        else $error("general pin two driven while set to float");
    chk_gpio_read: assert property (!gpio_cfg_r[0] |=> !GPIO_READBACK[0])
        else $error("driven-low general pin read back high");
    chk_monitor_inputs: assert property (mm |=> !GENERAL_PIN_ONE_OE && !GENERAL_PIN_TWO_OE
                                             && !WATCHDOG_OUT_N_OE && MONITOR_MODE)
        else $error("pin driven in monitor mode");
    chk_sdo_idle: assert property (!cs_act |=> !SERIAL_DATA_OUT_OD_OE && !SERIAL_DATA_OUT_OD_O)
        else $error("serial output driven without chip select");
    chk_discharge_hold: assert property (!(CFG_WR && match) && !WATCHDOG_ACTIVE
                                         |=> $stable(DISCHARGE_EN))
        else $error("discharge switches changed without host write");
    chk_ow_current: assert property (st_r == CV_WAIT && ow_r |-> TEST_CURRENT_EN)
        else $error("test current off during open-wire conversion");
    chk_normal_nocur: assert property (st_r == CV_IDLE && match && NORMAL_CELL_CONVERT_CMD
                                       && !OPEN_WIRE_CONVERT_CMD |=> !TEST_CURRENT_EN [*2])
        else $error("test current on during normal conversion");
    chk_addr_gate: assert property (st_r == CV_IDLE && !match |=> st_r == CV_IDLE)
        else $error("conversion started for another address");
    chk_adc_start: assert property (st_r == CV_IDLE && match && TEMP_CONVERT_CMD
                                    && !(OPEN_WIRE_CONVERT_CMD || NORMAL_CELL_CONVERT_CMD)
                                    |=> ADC_START && MUX_SEL == 4'hC ##1 !ADC_START)
        else $error("temperature conversion start wrong");

    cov_wdt_fire: cover property (!WATCHDOG_ACTIVE ##1 WATCHDOG_ACTIVE);
    cov_ow_done: cover property (ow_r && st_r == CV_WAIT && ADC_DONE && MUX_SEL == LAST_CELL);
    cov_temp_done: cover property (st_r == CV_WAIT && ADC_DONE && MUX_SEL == 4'hD);
    cov_monitor: cover property (MONITOR_MODE && CELL_COUNT_SEL != 3'h0);

endmodule : bcmpc_pin_ctrl

// ### sim/bcmpc_host_model.sv
// Host processor model: frames the serial port and pulls up the shared data line
module bcmpc_host_model (
    output logic      sck,
    output logic      cs_n,
    input  wire logic sdo_oe,
    input  wire logic sdo_o,
    output logic      sdo_line
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam realtime HALF = 24.0;

    // External pull-up: a released line reads high, never a stale level
    assign sdo_line = sdo_oe ? sdo_o : 1'h1;

    initial begin
        sck  = 1'h0;
        cs_n = 1'h1;
    end

    task automatic set_cs(input logic lvl);
        cs_n = lvl;
        #(HALF);
    endtask : set_cs

    // Clock stands still outside frames; even counts leave it low
    task automatic pulse_sck(input int n);
        repeat (n) begin
            #(HALF);
            sck = ~sck;
        end
    endtask : pulse_sck

    task automatic frame(input int n);
        set_cs(1'h0);
        pulse_sck(n);
        #(HALF);
        set_cs(1'h1);
    endtask : frame
endmodule : bcmpc_host_model

// ### sim/tb.sv
// Self-checking bench for the pin control, watchdog and conversion block
`include "bcmpc_consts.svh"
module tb
    import bcmpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned WDT   = 600;
    localparam int unsigned CELLS = `BCMPC_CELL_COUNT;

    logic             clk, rst_n, mm_n, top_of_stack_sel, ncmd, ocmd, tcmd, cfg_wr, poll, sdo_bit;
    logic             adc_done, wdt_ext, sdo_o, sdo_oe, wdt_o, wdt_oe;
    logic             gp1_o, gp1_oe, gp2_o, gp2_oe, mon, amatch, wdt_act, busy, adc_start, tce;
    logic [3:0]       straps, cmd_addr, rd_idx, dev_addr, mux;
    logic [1:0]       cfg_gpio, gp_ext, gp_rb;
    logic [2:0]       ccs;
    logic [CELLS-1:0] cfg_dis, dis_en, d;
    bcmpc_word_t      adc_data, rd_data;
    bcmpc_word_t      res [16];
    wire              sck, cs_n, sdo_line;
    wire              gp1_w = gp1_oe ? gp1_o : gp_ext[0];
    wire              gp2_w = gp2_oe ? gp2_o : gp_ext[1];
    wire              wdt_w = wdt_oe ? wdt_o : wdt_ext;
    logic [31:0]      exp_q [$];
    int               id_q [$];
    int               n_mismatch, num_checks;
    event             smp;

    bcmpc_pin_ctrl #(.WDT_CYCLES(WDT), .CELLS(CELLS)) uut (
        .REF_CLK(clk), .RESET_N(rst_n), .SERIAL_CLOCK_IN(sck), .CHIP_SELECT_IN_N(cs_n),
        .MONITOR_MODE_SEL_N(mm_n), .TOP_OF_STACK_SEL(top_of_stack_sel), .ADDR_STRAP_BIT0(straps[0]),
        .ADDR_STRAP_BIT1(straps[1]), .ADDR_STRAP_BIT2(straps[2]), .ADDR_STRAP_BIT3(straps[3]),
        .SERIAL_DATA_OUT_OD_I(sdo_line), .SERIAL_DATA_OUT_OD_O(sdo_o),
        .SERIAL_DATA_OUT_OD_OE(sdo_oe), .WATCHDOG_OUT_N_I(wdt_w), .WATCHDOG_OUT_N_O(wdt_o),
        .WATCHDOG_OUT_N_OE(wdt_oe), .GENERAL_PIN_ONE_I(gp1_w), .GENERAL_PIN_ONE_O(gp1_o),
        .GENERAL_PIN_ONE_OE(gp1_oe), .GENERAL_PIN_TWO_I(gp2_w), .GENERAL_PIN_TWO_O(gp2_o),
        .GENERAL_PIN_TWO_OE(gp2_oe), .CMD_ADDR(cmd_addr), .CFG_WR(cfg_wr),
        .CFG_GPIO_WDATA(cfg_gpio), .CFG_DISCHARGE_WDATA(cfg_dis), .NORMAL_CELL_CONVERT_CMD(ncmd),
        .OPEN_WIRE_CONVERT_CMD(ocmd), .TEMP_CONVERT_CMD(tcmd), .POLL_MODE(poll),
        .SDO_BIT(sdo_bit), .ADC_DONE(adc_done), .ADC_DATA(adc_data), .RD_IDX(rd_idx),
        .DISCHARGE_EN(dis_en), .GPIO_READBACK(gp_rb), .MONITOR_MODE(mon),
        .CELL_COUNT_SEL(ccs), .DEVICE_ADDR(dev_addr), .ADDR_MATCH(amatch),
        .WATCHDOG_ACTIVE(wdt_act), .CONV_BUSY(busy), .ADC_START(adc_start), .MUX_SEL(mux),
        .TEST_CURRENT_EN(tce), .RD_DATA(rd_data));

    bcmpc_host_model host (.sck(sck), .cs_n(cs_n), .sdo_oe(sdo_oe), .sdo_o(sdo_o),
                           .sdo_line(sdo_line));

    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [31:0] obs(input int id);
        case (id)
            0: obs = 32'(dis_en);
            1: obs = {30'h0, gp2_oe, gp1_oe};
            2: obs = {30'h0, gp_rb};
            3: obs = {28'h0, dev_addr};
            4: obs = {29'h0, wdt_act, wdt_oe, wdt_w};
            5: obs = {28'h0, mon, ccs};
            6: obs = {26'h0, busy, tce, mux};
            7: obs = {20'h0, rd_data};
            8: obs = {31'h0, sdo_line};
            10: obs = {29'h0, amatch, gp2_w, gp1_w};
            default: obs = {30'h0, busy, tce};
        endcase
    endfunction : obs

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        num_checks++;
        if (seen !== expv) begin
            n_mismatch++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, expv);
        end
    endtask : check

    // The driver only notes expectations; this process does the comparing
    always @(smp) while (exp_q.size() > 0) check(obs(id_q.pop_front()), exp_q.pop_front());

    task automatic note(input int id, input logic [31:0] e);
        id_q.push_back(id);
        exp_q.push_back(e);
        -> smp;
    endtask : note

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic cfg_write(input logic [3:0] a, input logic [1:0] g, input logic [CELLS-1:0] v);
        cmd_addr = a;
        cfg_gpio = g;
        cfg_dis = v;
        cfg_wr = 1'h1;
        cyc(1);
        cfg_wr = 1'h0;
    endtask : cfg_write

    task automatic conv(input int kind, input int first, input int last, input logic tc,
                        input logic [31:0] sdo_exp);
        int k;
        cmd_addr = straps;
        ocmd = (kind == 1);
        ncmd = (kind == 0);
        tcmd = (kind == 2);
        cyc(1);
        {ocmd, ncmd, tcmd} = 3'h0;
        for (int ch = first; ch <= last; ch++) begin
            k = 0;
            while (adc_start !== 1'h1 && k < 20) begin
                cyc(1);
                k++;
            end
            note(6, {26'h0, 1'h1, tc, 4'(ch)});
            // Serial output follows its source (data bit, busy flag or poll toggle) one cycle late
            cyc(1 + $urandom_range(2, 0));
            if (ch == first) note(8, sdo_exp);
            adc_data = 12'($urandom);
            res[ch] = adc_data;
            adc_done = 1'h1;
            cyc(1);
            adc_done = 1'h0;
        end
        cyc(1);
        note(9, 32'h0);
    endtask : conv

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    initial begin
        #200000;
        n_mismatch++;
        final_report();
    end

    initial begin
        void'($urandom(32'hE3B9));
        {rst_n, ncmd, ocmd, tcmd, cfg_wr, poll, sdo_bit, adc_done} = 8'h0;
        {mm_n, top_of_stack_sel, wdt_ext, gp_ext} = 5'h1F;
        straps = 4'($urandom);
        {cmd_addr, rd_idx, cfg_gpio, cfg_dis, adc_data} = '0;
        foreach (res[i]) res[i] = 12'h0;
        repeat (3) @(posedge clk);
        #1 rst_n = 1'h1;
        cyc(4);
        note(0, 32'h0);
        note(1, 32'h0);
        note(2, 32'h3);
        note(3, {28'h0, straps});
        note(4, 32'h1);
        $display("test reset defaults done");
        host.frame(8);
        cyc(1);
        for (int g = 0; g < 4; g++) begin
            gp_ext = 2'($urandom);
            d = CELLS'($urandom);
            cfg_write(straps, 2'(g), d);
            cyc(5);
            note(0, 32'(d));
            note(1, 32'(~g & 3));
            note(2, 32'(g & gp_ext));
        end
        cfg_write(straps ^ 4'h1, 2'h0, ~d);
        cyc(3);
        note(0, 32'(d));
        note(1, 32'h0);
        $display("test config and pins done");
        cfg_write(straps, 2'h0, d);
        mm_n = 1'h0;
        {wdt_ext, gp_ext} = 3'($urandom);
        cyc(6);
        note(5, {28'h0, 1'h1, wdt_ext, gp_ext});
        note(1, 32'h0);
        note(4, {31'h0, wdt_ext});
        cyc(1);
        mm_n = 1'h1;
        {wdt_ext, gp_ext} = 3'h7;
        cyc(6);
        note(5, 32'h0);
        note(1, 32'h3);
        note(10, 32'h4);
        $display("test monitor mode done");
        host.frame(8);
        cyc(1);
        cmd_addr = ~straps;
        ocmd = 1'h1;
        cyc(1);
        ocmd = 1'h0;
        cyc(3);
        note(9, 32'h0);
        host.set_cs(1'h0);
        cyc(1);
        sdo_bit = 1'($urandom);
        cyc(2);
        conv(1, 0, CELLS - 1, 1'h1, {31'h0, sdo_bit});
        poll = 1'h1;
        conv(0, 0, CELLS - 1, 1'h0, 32'h0);
        top_of_stack_sel = 1'h0;
        cyc(4);
        conv(2, `BCMPC_CH_TEMP1, `BCMPC_CH_TEMP2, 1'h0, 32'h1);
        host.set_cs(1'h1);
        cyc(4);
        note(8, 32'h1);
        for (int i = 0; i < 16; i++) begin
            rd_idx = 4'(i);
            cyc(2);
            note(7, (i < 14) ? 32'(res[i]) : 32'h0);
        end
        $display("test conversions done");
        cfg_write(straps, 2'h0, '1);
        host.frame(8);
        cyc(WDT - 30);
        note(4, 32'h1);
        cyc(60);
        note(4, 32'h6);
        note(0, 32'h0);
        note(1, 32'h0);
        cfg_write(straps, 2'h0, '1);
        cyc(3);
        note(0, 32'h0);
        host.frame(4);
        cyc(5);
        note(4, 32'h1);
        $display("test watchdog done");
        rst_n = 1'h0;
        straps = ~straps;
        cyc(3);
        rst_n = 1'h1;
        cyc(4);
        note(3, {28'h0, straps});
        note(0, 32'h0);
        note(10, 32'h3);
        cmd_addr = straps;
        cyc(1);
        note(10, 32'h7);
        $display("test strap change done");
        cyc(2);
        final_report();
    end
endmodule : tb
